// ==== verilog/core_bus_cfg.svh ====
// constants for the core memory bus interface
`ifndef CORE_BUS_CFG_SVH
`define CORE_BUS_CFG_SVH
`define CB_ADDR_W      32
`define CB_DATA_W      32
`define CB_SIZE_BYTE   2'h0
`define CB_SIZE_HALF   2'h1
`define CB_SIZE_WORD   2'h2
`define CB_SIZE_BAD    2'h3
`define CB_KIND_IDLE   2'h0
`define CB_KIND_COPROC 2'h1
`define CB_KIND_NSEQ   2'h2
`define CB_KIND_SEQ    2'h3
`define CB_OP_IDLE     2'h0
`define CB_OP_COPROC   2'h1
`define CB_OP_MEM      2'h2
`define CB_ACCESS_PROTECTION_FETCH  0
`define CB_ACCESS_PROTECTION_PRIV   1
`define CB_RST_ADDR    32'h0000_0000
`define CB_RST_DATA    32'h0000_0000
`endif

// ==== verilog/core_bus_pkg.sv ====
// types for the core memory bus interface
`include "core_bus_cfg.svh"
package core_bus_pkg;
	typedef struct packed {
		logic [1:0]              op;
		logic [`CB_ADDR_W-1:0]   addr;
		logic [`CB_DATA_W-1:0]   wdata;
		logic                    write;
		logic [1:0]              size;
		logic                    fetch;
		logic                    user;
		logic                    swap;
		logic                    multi;
	} req_t;
	typedef struct packed {
		logic                    valid;
		logic [`CB_DATA_W-1:0]   data;
		logic                    abort;
	} rd_t;
	typedef enum logic {
		DBG_RUN,
		DBG_HALT
	} dbg_state_t;
endpackage : core_bus_pkg

// ==== verilog/core_bus_if.sv ====
// core side of the pipelined memory bus interface
// Overview of operation
// - width code 00 byte, 01 half, 10 word
// - next kind 00 idle, 10 new, 11 sequential
// - next kind 01 for coprocessor transfer
// - address-class outputs change on rising edge
// - coprocessor absent and busy edge sampled
// - test signals synchronous, enable pulse supplied
// - debug advances only when qualifier high
// - interrupt requests synchronous, edge sampled
// - protection bits low for fetch, user
// - lock asserted for atomic swap cycles
// - multi flag during load/store multiple
// - core reset low resets immediately
// - stall enable high advances, low holds
// - address leads its data cycle
`timescale 1ns/10ps
`include "core_bus_cfg.svh"
module core_bus_if (
	input  wire logic                    i_clk_sys,
	input  wire logic                    i_rst,
	input  wire logic                    i_core_reset_n,
	input  wire logic                    i_stall_enable,
	input  wire logic                    i_abort,
	input  wire logic [`CB_DATA_W-1:0]   i_rdata,
	input  wire logic                    i_coproc_absent,
	input  wire logic                    i_coproc_busy,
	input  wire logic                    i_normal_int_req_n,
	input  wire logic                    i_fast_int_req_n,
	input  wire logic                    i_ext_debug_request,
	input  wire logic                    i_debug_clock_qualifier,
	input  wire logic                    i_test_clock_enable,
	input  wire logic                    i_req_valid,
	input  wire core_bus_pkg::req_t      i_req,
	output logic [`CB_ADDR_W-1:0]        o_addr,
	output logic                         o_write,
	output logic [1:0]                   o_size,
	output logic [1:0]                   o_access_protection,
	output logic                         o_lock,
	output logic [1:0]                   o_next_cycle_kind,
	output logic                         o_multi_transfer_flag,
	output logic [`CB_DATA_W-1:0]        o_wdata,
	output logic                         o_req_taken,
	output core_bus_pkg::rd_t            o_rd,
	output logic                         o_coproc_absent,
	output logic                         o_coproc_busy,
	output logic                         o_normal_int_pend,
	output logic                         o_fast_int_pend,
	output logic                         o_debug_ack,
	output logic [7:0]                   o_debug_ticks
);

	// combined reset
	logic                     rst_any;
	logic                     advance;
	logic                     take;
	logic                     take_mem;
	logic [1:0]               size_fix;
	logic [`CB_ADDR_W-1:0]    next_seq_addr;
	logic                     is_seq;
	logic [1:0]               kind_nxt;

	// address phase state
	logic                     ap_mem_r;
	logic                     ap_write_r;
	logic [`CB_DATA_W-1:0]    ap_wdata_r;

	// data phase state
	logic                     dp_read_r;

	core_bus_pkg::dbg_state_t dbg_state_r;
	logic                     dbg_tick;

	assign rst_any = i_rst | ~i_core_reset_n;

	assign advance = i_stall_enable;

	assign take = advance & i_req_valid & (dbg_state_r == core_bus_pkg::DBG_RUN);

	assign take_mem = take & (i_req.op == `CB_OP_MEM);

	always_comb begin
		size_fix = i_req.size;
		if (i_req.size == `CB_SIZE_BAD) begin
			size_fix = `CB_SIZE_WORD;
		end
	end

	assign next_seq_addr = o_addr + (`CB_ADDR_W'(1) << o_size);

	assign is_seq = ap_mem_r & (i_req.addr == next_seq_addr);

	always_comb begin
		kind_nxt = `CB_KIND_IDLE;
		if (take) begin
			unique case (i_req.op)
				`CB_OP_MEM: begin
					kind_nxt = is_seq ? `CB_KIND_SEQ : `CB_KIND_NSEQ;
				end
				`CB_OP_COPROC: begin
					kind_nxt = `CB_KIND_COPROC;
				end
				default: begin
					kind_nxt = `CB_KIND_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			o_addr <= `CB_RST_ADDR;
		end else if (take_mem) begin
			o_addr <= i_req.addr;
		end
	end

	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			o_size <= `CB_SIZE_WORD;
		end else if (take_mem) begin
			o_size <= size_fix;
		end
	end

	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			o_access_protection <= 2'h0;
		end else if (take_mem) begin
			o_access_protection[`CB_ACCESS_PROTECTION_FETCH] <= ~i_req.fetch;
			o_access_protection[`CB_ACCESS_PROTECTION_PRIV]  <= ~i_req.user;
		end
	end

	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			o_write <= 1'b0;
		end else if (take_mem) begin
			o_write <= i_req.write;
		end else if (advance) begin
			o_write <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			o_lock <= 1'b0;
		end else if (take_mem) begin
			o_lock <= i_req.swap;
		end else if (advance) begin
			o_lock <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			o_next_cycle_kind <= `CB_KIND_IDLE;
		end else if (advance) begin
			o_next_cycle_kind <= kind_nxt;
		end
	end

	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			o_multi_transfer_flag <= 1'b0;
		end else if (take) begin
			o_multi_transfer_flag <= i_req.multi & (i_req.op == `CB_OP_MEM);
		end else if (advance) begin
			o_multi_transfer_flag <= 1'b0;
		end
	end

	// address phase bookkeeping
	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			ap_mem_r   <= 1'b0;
			ap_write_r <= 1'b0;
			ap_wdata_r <= `CB_RST_DATA;
		end else if (advance) begin
			ap_mem_r   <= take & (i_req.op == `CB_OP_MEM);
			ap_write_r <= take & (i_req.op == `CB_OP_MEM) & i_req.write;
			ap_wdata_r <= i_req.wdata;
		end
	end

	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			o_wdata <= `CB_RST_DATA;
		end else if (advance && ap_write_r) begin
			o_wdata <= ap_wdata_r;
		end
	end

	// data phase read marker
	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			dp_read_r <= 1'b0;
		end else if (advance) begin
			dp_read_r <= ap_mem_r & ~ap_write_r;
		end
	end

	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			o_rd <= '0;
		end else begin
			o_rd.valid <= advance & dp_read_r;
			if (advance && dp_read_r) begin
				o_rd.data  <= i_rdata;
				o_rd.abort <= i_abort;
			end
		end
	end

	// request handshake
	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			o_req_taken <= 1'b0;
		end else begin
			o_req_taken <= take;
		end
	end

	edge_sample #(
		.RST_VAL (1'b1),
		.INVERT  (1'b0)
	) u_coproc_absent (
		.i_clk_sys (i_clk_sys),
		.i_rst     (rst_any),
		.i_pin     (i_coproc_absent),
		.o_level   (o_coproc_absent)
	);

	edge_sample #(
		.RST_VAL (1'b1),
		.INVERT  (1'b0)
	) u_coproc_busy (
		.i_clk_sys (i_clk_sys),
		.i_rst     (rst_any),
		.i_pin     (i_coproc_busy),
		.o_level   (o_coproc_busy)
	);

	edge_sample #(
		.RST_VAL (1'b0),
		.INVERT  (1'b1)
	) u_normal_int (
		.i_clk_sys (i_clk_sys),
		.i_rst     (rst_any),
		.i_pin     (i_normal_int_req_n),
		.o_level   (o_normal_int_pend)
	);

	edge_sample #(
		.RST_VAL (1'b0),
		.INVERT  (1'b1)
	) u_fast_int (
		.i_clk_sys (i_clk_sys),
		.i_rst     (rst_any),
		.i_pin     (i_fast_int_req_n),
		.o_level   (o_fast_int_pend)
	);

	assign dbg_tick = i_debug_clock_qualifier & i_test_clock_enable;

	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			dbg_state_r <= core_bus_pkg::DBG_RUN;
		end else if (dbg_tick) begin
			unique case (dbg_state_r)
				core_bus_pkg::DBG_RUN: begin
					if (i_ext_debug_request) begin
						dbg_state_r <= core_bus_pkg::DBG_HALT;
					end
				end
				core_bus_pkg::DBG_HALT: begin
					if (!i_ext_debug_request) begin
						dbg_state_r <= core_bus_pkg::DBG_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			o_debug_ticks <= 8'h00;
		end else if (dbg_tick) begin
			o_debug_ticks <= o_debug_ticks + 8'h01;
		end
	end

	// halted state shown one cycle later
	always_ff @(posedge i_clk_sys or posedge rst_any) begin
		if (rst_any) begin
			o_debug_ack <= 1'b0;
		end else begin
			o_debug_ack <= (dbg_state_r == core_bus_pkg::DBG_HALT);
		end
	end

endmodule : core_bus_if

// one edge sampled input, optional inversion
module edge_sample #(
	parameter logic RST_VAL = 1'b0,
	parameter bit   INVERT  = 1'b0
) (
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	input  wire logic i_pin,
	output logic      o_level
);

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_level <= RST_VAL;
		end else begin
			o_level <= i_pin ^ INVERT;
		end
	end

endmodule : edge_sample

// ==== verif/core_bus_if_props.sv ====
// assertion checker for the core memory bus interface
`timescale 1ns/10ps
module core_bus_if_props (
	input logic i_clk_sys,
	input logic i_rst,
	input logic i_core_reset_n,
	input logic i_stall_enable,
	input logic [31:0] i_rdata,
	input logic i_abort,
	input core_bus_pkg::req_t i_req,
	input logic [31:0] o_addr,
	input logic o_write,
	input logic [1:0] o_size,
	input logic [1:0] o_access_protection,
	input logic o_lock,
	input logic [1:0] o_next_cycle_kind,
	input logic o_req_taken,
	input core_bus_pkg::rd_t o_rd
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst || !i_core_reset_n);
	sequence mem_take;
		o_req_taken && $past(i_req.op) == 2'h2;
	endsequence
	chk_size_code: assert property (mem_take |-> o_size ==
		($past(i_req.size) == 2'h3 ? 2'h2 : $past(i_req.size))) else $error("bad size");
	chk_kind_cop: assert property (o_req_taken && $past(i_req.op) == 2'h1
		|-> o_next_cycle_kind == 2'h1) else $error("bad kind");
	chk_addr_hold: assert property ($changed(o_addr) |-> o_req_taken)
		else $error("address moved");
	chk_access_protection_bits: assert property (mem_take |->
		o_access_protection == ~{$past(i_req.user), $past(i_req.fetch)}) else $error("bad access_protection");
	chk_lock_swap: assert property (mem_take |-> o_lock == $past(i_req.swap))
		else $error("bad lock");
	chk_write_flag: assert property (mem_take |-> o_write == $past(i_req.write))
		else $error("bad write");
	chk_stall_hold: assert property (!i_stall_enable |=> !o_req_taken)
		else $error("taken in wait");
	chk_read_data: assert property (o_rd.valid |-> o_rd.data == $past(i_rdata)
		&& o_rd.abort == $past(i_abort)) else $error("bad read");
	cover property (o_rd.valid && o_rd.abort);
	cover property (o_lock && o_write);
	cover property (o_next_cycle_kind == 2'h3);
endmodule : core_bus_if_props

// ==== verif/core_bus_mem_model.sv ====
// memory partner model with optional wait states
`timescale 1ns/10ps
module core_bus_mem_model (
	input logic i_clk_sys,
	input logic i_slow,
	input logic [31:0] i_addr,
	input logic i_write,
	input logic [31:0] i_wdata,
	output logic o_stall_enable,
	output logic [31:0] o_rdata,
	output logic o_abort
);
	logic [31:0] mem_r [16];
	logic [31:0] wa_r;
	logic we_r;
	logic ph_r;
	initial begin
		mem_r = '{default: 32'h0};
		{o_stall_enable, o_rdata, o_abort, wa_r, we_r, ph_r} = {1'b1, 67'h0};
	end
	always @(posedge i_clk_sys) begin
		ph_r <= ~ph_r;
		o_stall_enable <= ~i_slow | ph_r;
		// latched address, fault above 2 GB
		if (o_stall_enable) begin
			wa_r <= i_addr;
			we_r <= i_write;
			if (we_r)
				mem_r[wa_r[5:2]] <= i_wdata;
			o_rdata <= i_write ? ~o_rdata : mem_r[i_addr[5:2]];
			o_abort <= i_addr[31];
		end
	end
endmodule : core_bus_mem_model

// ==== verif/core_bus_if_test.sv ====
// self-checking bench for the core memory bus interface
`timescale 1ns/10ps
module core_bus_if_test;
	logic i_clk_sys, i_rst, i_core_reset_n, i_stall_enable, i_abort, i_req_valid, slow;
	logic i_coproc_absent, i_coproc_busy, i_normal_int_req_n, i_fast_int_req_n;
	logic i_ext_debug_request, i_debug_clock_qualifier, i_test_clock_enable;
	logic o_write, o_lock, o_multi_transfer_flag, o_req_taken, o_coproc_absent;
	logic o_coproc_busy, o_normal_int_pend, o_fast_int_pend, o_debug_ack;
	logic [31:0] i_rdata, o_addr, o_wdata;
	logic [1:0] o_size, o_access_protection, o_next_cycle_kind;
	logic [7:0] o_debug_ticks;
	core_bus_pkg::req_t i_req;
	core_bus_pkg::rd_t o_rd;
	int num_errors, n_tests;
	core_bus_if DUT (.i_clk_sys, .i_rst, .i_core_reset_n, .i_stall_enable, .i_abort, .i_rdata,
		.i_coproc_absent, .i_coproc_busy, .i_normal_int_req_n, .i_fast_int_req_n,
		.i_ext_debug_request, .i_debug_clock_qualifier, .i_test_clock_enable, .i_req_valid,
		.i_req, .o_addr, .o_write, .o_size, .o_access_protection, .o_lock, .o_next_cycle_kind,
		.o_multi_transfer_flag, .o_wdata, .o_req_taken, .o_rd, .o_coproc_absent, .o_coproc_busy,
		.o_normal_int_pend, .o_fast_int_pend, .o_debug_ack, .o_debug_ticks);
	core_bus_mem_model u_mem (.i_clk_sys, .i_slow(slow), .i_addr(o_addr), .i_write(o_write),
		.i_wdata(o_wdata), .o_stall_enable(i_stall_enable), .o_rdata(i_rdata), .o_abort(i_abort));
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	task automatic test_done();
		if (num_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask : check
	task automatic send(input logic [1:0] op, input logic [31:0] a, input logic [31:0] d,
		input logic [6:0] f, input logic hold);
		int n;
		i_req_valid <= 1'b1;
		i_req <= {op, a, d, f};
		n = 0;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (i_stall_enable !== 1'b1 && n < 20);
		if (i_stall_enable !== 1'b1) begin
			num_errors++;
			test_done();
		end
		if (!hold)
			i_req_valid <= 1'b0;
	endtask : send
	task automatic get_rd(input logic [31:0] d, input logic ab);
		int n;
		n = 0;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_rd.valid !== 1'b1 && n < 20);
		check(32'(o_rd.valid), 32'h1);
		if (o_rd.valid !== 1'b1)
			test_done();
		check(o_rd.data, d);
		check(32'(o_rd.abort), 32'(ab));
	endtask : get_rd
	task automatic t_rw();
		send(2'h2, 32'h10, 32'ha5a5_0f0f, 7'b1_10_0000, 1'b0);
		@(posedge i_clk_sys);
		slow <= 1'b1;
		check(o_addr, 32'h10);
		check(32'({o_write, o_access_protection}), 32'h7);
		send(2'h2, 32'h10, 32'h0, 7'b0_10_1100, 1'b0);
		@(posedge i_clk_sys);
		check(32'({o_write, o_access_protection}), 32'h0);
		get_rd(32'ha5a5_0f0f, 1'b0);
		slow <= 1'b0;
	endtask : t_rw
	task automatic t_kind();
		for (int s = 0; s < 4; s++) begin
			send(2'h2, 32'h40, 32'h0, {1'b0, 2'(s), 4'h0}, 1'b0);
			@(posedge i_clk_sys);
			check(32'(o_size), (s == 3) ? 32'h2 : 32'(s));
			check(32'(o_next_cycle_kind), 32'h2);
		end
		send(2'h2, 32'h80, 32'h0, 7'b0_10_0000, 1'b1);
		send(2'h2, 32'h84, 32'h0, 7'b0_10_0000, 1'b0);
		@(posedge i_clk_sys);
		check(32'(o_next_cycle_kind), 32'h3);
		send(2'h1, 32'h0, 32'h0, 7'h0, 1'b0);
		@(posedge i_clk_sys);
		check(32'(o_next_cycle_kind), 32'h1);
		check(o_addr, 32'h84);
		send(2'h2, 32'h8000_0010, 32'h0, 7'b0_10_0000, 1'b0);
		get_rd(32'ha5a5_0f0f, 1'b1);
	endtask : t_kind
	task automatic t_swap();
		send(2'h2, 32'h10, 32'h0, 7'b0_10_0010, 1'b1);
		send(2'h2, 32'h10, 32'h1234_5678, 7'b1_10_0010, 1'b0);
		@(posedge i_clk_sys);
		check(32'({o_lock, o_write}), 32'h3);
		send(2'h2, 32'h14, 32'h0, 7'b0_10_0001, 1'b0);
		@(posedge i_clk_sys);
		check(32'({o_lock, o_multi_transfer_flag}), 32'h1);
	endtask : t_swap
	task automatic t_reset();
		i_core_reset_n <= 1'b0;
		#5;
		check(o_addr, 32'h0);
		check(32'(o_size), 32'h2);
		@(posedge i_clk_sys);
		i_core_reset_n <= 1'b1;
		@(posedge i_clk_sys);
	endtask : t_reset
	task automatic t_side();
		i_coproc_absent <= 1'b0;
		i_normal_int_req_n <= 1'b0;
		i_ext_debug_request <= 1'b1;
		i_debug_clock_qualifier <= 1'b1;
		@(posedge i_clk_sys);
		check(32'({o_coproc_absent, o_coproc_busy, o_normal_int_pend, o_fast_int_pend}), 32'hc);
		i_test_clock_enable <= 1'b1;
		@(posedge i_clk_sys);
		check(32'({o_coproc_absent, o_coproc_busy, o_normal_int_pend, o_fast_int_pend}), 32'h6);
		check(32'(o_debug_ticks), 32'h0);
		i_test_clock_enable <= 1'b0;
		i_req_valid <= 1'b1;
		i_req <= {2'h2, 32'h20, 32'h0, 7'b0_10_0000};
		@(posedge i_clk_sys);
		check(32'({o_debug_ticks, o_debug_ack}), 32'h2);
		i_ext_debug_request <= 1'b0;
		@(posedge i_clk_sys);
		check(32'({o_req_taken, o_debug_ack}), 32'h1);
		i_test_clock_enable <= 1'b1;
		@(posedge i_clk_sys);
		i_test_clock_enable <= 1'b0;
		@(posedge i_clk_sys);
		@(posedge i_clk_sys);
		check(32'({o_debug_ticks, o_req_taken}), 32'h5);
		i_req_valid <= 1'b0;
	endtask : t_side
	initial begin
		num_errors = 0;
		n_tests = 0;
		{i_rst, i_core_reset_n, slow, i_req_valid, i_req} = {2'b11, 75'h0};
		{i_coproc_absent, i_coproc_busy, i_normal_int_req_n, i_fast_int_req_n} = 4'hf;
		{i_ext_debug_request, i_debug_clock_qualifier, i_test_clock_enable} = 3'h0;
		repeat (8) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		@(posedge i_clk_sys);
		t_rw();
		t_kind();
		t_swap();
		t_reset();
		t_side();
		test_done();
	end
endmodule : core_bus_if_test
bind core_bus_if core_bus_if_props chk (.i_clk_sys, .i_rst, .i_core_reset_n, .i_stall_enable,
	.i_rdata, .i_abort, .i_req, .o_addr, .o_write, .o_size, .o_access_protection, .o_lock,
	.o_next_cycle_kind, .o_req_taken, .o_rd);
